// ==== hdl/system_reset_power_manager.sv ====
/*
 * System reset and power manager: power-up delay, oscillator start-up count, watchdog, clock fail monitor,
 * reset combiner, clock source switching, low-supply flag, Sleep and Idle sequencing.
 * Assumes analog events (power-on, brown-out, supply comparator) arrive as asynchronous levels, the watchdog
 * oscillator and primary oscillator are sampled as tick levels, and registers are reached over a plain port.
 */
// How it works
// - 10-bit counter holds clock for 1024 cycles
// - Start-up count reruns after power-on, brown-out, Sleep
// - Count only in crystal modes
// - Power-up delay only after power-on
// - Watchdog counts low-power RC ticks, free-running
// - Fuse bit or soft bit enables watchdog
// - Overflow resets, but only wakes in Sleep
// - Monitor keeps RC oscillator on outside Sleep
// - Failure raises trap, falls back to fast RC
// - Any reset cause asserts master reset
// - Fuse source at power-on and brown-out, software switches later
// - Supply flag from selected tap below reference
// - Sleep stops clock, peripherals and monitor
// - Watchdog cleared entering Sleep, RC stays on while watchdog enabled
// - Supply and brown-out detectors live in Sleep
// - Sleep exits on interrupt, reset, watchdog
// - Idle halts CPU, clears watchdog
// - Idle stops peripherals with stop bit set
// - Idle wake re-applies CPU clock at once
`timescale 1ns/1ns
`include "sysmgr_defs.svh"

module system_reset_power_manager
	import sysmgr_pkg::*;
#(
	parameter int PWRUP_CYCLES = `PWRUP_DELAY_CYCLES,
	parameter int NUM_PERIPH = 16,
	parameter logic [2:0] FUSE_CLK_SRC = 3'h3
) (
	input wire logic CLOCK,
	input wire logic SYS_RST,
	input wire logic POWER_ON_EVENT,
	input wire logic BROWNOUT_EVENT,
	input wire logic MASTER_CLEAR_PIN_N,
	input wire logic RESET_INSTRUCTION,
	input wire logic TRAP_CONFLICT,
	input wire logic ILLEGAL_OP,
	input wire logic WATCHDOG_FUSE_ENABLE,
	input wire logic CLOCK_FAIL_MONITOR_EN,
	input wire logic BROWNOUT_EN,
	input wire logic RC_OSC_TICK,
	input wire logic PRIMARY_OSC_TICK,
	input wire logic [15:0] SUPPLY_TAP_BELOW,
	input wire logic SUPPLY_DETECT_EXT_INPUT,
	input wire logic POWER_SAVE_INSTRUCTION,
	input wire logic POWER_SAVE_SLEEP,
	input wire logic IRQ_PENDING,
	input wire logic [3:0] ADDR,
	input wire logic [15:0] WDATA,
	input wire logic WR_STB,
	input wire logic RD_STB,
	output logic [15:0] RDATA,
	output logic MASTER_RESET,
	output logic CPU_CLOCK_EN,
	output logic SYS_CLOCK_EN,
	output logic [NUM_PERIPH-1:0] PERIPH_CLOCK_EN,
	output logic [2:0] CLOCK_SOURCE,
	output logic CLOCK_FAIL_TRAP,
	output logic RC_OSC_ENABLE,
	output logic SUPPLY_DETECT_FLAG,
	output logic DETECTORS_ACTIVE,
	output logic WAKE_EVENT
);
	// ------------------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------------------
	localparam int NSYNC = 24;
	// Reset value of the synchroniser stages: each input at its idle level, so the active-low
	// clear pin does not look asserted for two cycles after reset.
	localparam logic [NSYNC-1:0] SYNC_IDLE = 24'h000010;
	logic [NSYNC-1:0] async_in;
	logic [NSYNC-1:0] sync1_ff;
	logic [NSYNC-1:0] sync2_ff;
	assign async_in = {SUPPLY_TAP_BELOW, SUPPLY_DETECT_EXT_INPUT, PRIMARY_OSC_TICK, RC_OSC_TICK,
		MASTER_CLEAR_PIN_N, BROWNOUT_EVENT, POWER_ON_EVENT, CLOCK_FAIL_MONITOR_EN, WATCHDOG_FUSE_ENABLE};

	// Two flops per asynchronous input; only the second stage is read.
	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			sync1_ff <= SYNC_IDLE;
			sync2_ff <= SYNC_IDLE;
		end else begin
			sync1_ff <= async_in;
			sync2_ff <= sync1_ff;
		end
	end

	logic fuse_wdog_en, clock_fail_monitor_en, por_s, bor_s, master_clear_pin_n_s, rc_tick_s, osc_tick_s, ext_supply_s;
	logic [15:0] tap_below_s;
	assign fuse_wdog_en = sync2_ff[0];
	assign clock_fail_monitor_en = sync2_ff[1];
	assign por_s = sync2_ff[2];
	assign bor_s = sync2_ff[3] & BROWNOUT_EN;
	assign master_clear_pin_n_s = sync2_ff[4];
	assign rc_tick_s = sync2_ff[5];
	assign osc_tick_s = sync2_ff[6];
	assign ext_supply_s = sync2_ff[7];
	assign tap_below_s = sync2_ff[23:8];

	// ------------------------------------------------------------------------
	// State and registers
	// ------------------------------------------------------------------------
	pwr_state_e state_ff, nxt_state;
	logic [31:0] pwrup_cnt_ff;
	logic [`OSC_STARTUP_WIDTH-1:0] ost_cnt_ff;
	logic ost_done_ff;
	logic [`WDOG_WIDTH-1:0] wdog_cnt_ff;
	logic wdog_soft_en_ff;
	logic rc_prev_ff, osc_prev_ff;
	logic [5:0] fail_cnt_ff;
	logic fail_ff;
	logic [2:0] cur_src_ff, new_src_ff;
	logic [3:0] tap_sel_ff;
	logic ext_tap_ff, supply_en_ff, supply_flag_ff;
	logic [7:0] cause_ff;
	logic [NUM_PERIPH-1:0] idle_stop_ff;
	logic por_seen_ff;

	logic wdog_en, wdog_ovf, wdog_clr_wr, any_reset, crystal_mode, supply_low;
	logic [7:0] causes;
	assign wdog_en = fuse_wdog_en | wdog_soft_en_ff;
	assign wdog_ovf = wdog_en && rc_tick_s && !rc_prev_ff && (&wdog_cnt_ff);
	assign wdog_clr_wr = WR_STB && ADDR == `REG_WDOG && WDATA[`WDOG_CLEAR_BIT];
	// only crystal and resonator modes need the start-up count.
	assign crystal_mode = cur_src_ff inside {SRC_LOW_POWER_XTAL, SRC_LOW_RANGE_XTAL, SRC_STD_XTAL,
		SRC_HIGH_SPEED_XTAL};
	assign supply_low = supply_en_ff && (ext_tap_ff ? ext_supply_s : tap_below_s[tap_sel_ff]);

	// Cause vector: power-on, brown-out, instruction, pin, watchdog, trap, opcode, spare.
	assign causes = {1'b0, ILLEGAL_OP, TRAP_CONFLICT, wdog_ovf && state_ff != ST_SLEEP, !master_clear_pin_n_s,
		RESET_INSTRUCTION, bor_s, por_s};
	assign any_reset = |causes;

	// ------------------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------------------
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_POWERUP: if (pwrup_cnt_ff >= 32'(PWRUP_CYCLES)) nxt_state = ST_STARTUP;
			ST_STARTUP: if (ost_done_ff || !crystal_mode) nxt_state = ST_RUN;
			ST_RUN: if (POWER_SAVE_INSTRUCTION) nxt_state = POWER_SAVE_SLEEP ? ST_SLEEP : ST_IDLE;
			ST_IDLE: if (IRQ_PENDING || wdog_ovf) nxt_state = ST_RUN;
			ST_SLEEP: if (IRQ_PENDING || wdog_ovf) nxt_state = ST_STARTUP;
			ST_RESET: if (!any_reset) nxt_state = ST_STARTUP;
			default: nxt_state = ST_RESET;
		endcase
		// Power-on reinstates the full sequence; brown-out and other causes skip the power-up delay.
		if (por_s) begin
			nxt_state = ST_POWERUP;
		end else if (any_reset) begin
			nxt_state = ST_RESET;
		end
	end

	// State register.
	always_ff @(posedge CLOCK) begin
		if (SYS_RST) state_ff <= ST_POWERUP;
		else state_ff <= nxt_state;
	end

	// Power-up delay counter, runs only in the power-up state.
	always_ff @(posedge CLOCK) begin
		if (SYS_RST || state_ff != ST_POWERUP) pwrup_cnt_ff <= 32'h0;
		else if (pwrup_cnt_ff < 32'(PWRUP_CYCLES)) pwrup_cnt_ff <= pwrup_cnt_ff + 32'h1;
	end

	// Oscillator start-up counter, counts primary oscillator edges while starting.
	always_ff @(posedge CLOCK) begin
		osc_prev_ff <= SYS_RST ? 1'b0 : osc_tick_s;
		if (SYS_RST || state_ff != ST_STARTUP) begin
			ost_cnt_ff <= '0;
			ost_done_ff <= 1'b0;
		end else if (osc_tick_s && !osc_prev_ff && !ost_done_ff) begin
			ost_cnt_ff <= ost_cnt_ff + 1'b1;
			if (&ost_cnt_ff) ost_done_ff <= 1'b1;
		end
	end

	// Watchdog counter on low-power RC ticks; cleared by software and on Sleep or Idle entry.
	always_ff @(posedge CLOCK) begin
		rc_prev_ff <= SYS_RST ? 1'b0 : rc_tick_s;
		if (SYS_RST || any_reset || wdog_clr_wr || !wdog_en) begin
			wdog_cnt_ff <= '0;
		end else if (state_ff == ST_RUN && POWER_SAVE_INSTRUCTION) begin
			wdog_cnt_ff <= '0;
		end else if (rc_tick_s && !rc_prev_ff) begin
			wdog_cnt_ff <= wdog_cnt_ff + 1'b1;
		end
	end

	// Clock fail monitor: missing primary edges for too long flags failure; disabled in Sleep.
	always_ff @(posedge CLOCK) begin
		if (SYS_RST || !clock_fail_monitor_en || state_ff == ST_SLEEP || !crystal_mode || (osc_tick_s && !osc_prev_ff)) begin
			fail_cnt_ff <= '0;
		end else if (fail_cnt_ff != 6'(`FAIL_TIMEOUT)) begin
			fail_cnt_ff <= fail_cnt_ff + 6'h1;
		end
		if (SYS_RST || por_s) fail_ff <= 1'b0;
		else if (fail_cnt_ff == 6'(`FAIL_TIMEOUT - 1)) fail_ff <= 1'b1;
		else if (WR_STB && ADDR == `REG_CLKCTL && WDATA[`CLK_FAIL_BIT]) fail_ff <= 1'b0;
	end

	// Clock source: fuse choice on power-on and brown-out, software switch otherwise, fast RC on failure.
	always_ff @(posedge CLOCK) begin
		if (SYS_RST || por_s || bor_s) begin
			cur_src_ff <= FUSE_CLK_SRC;
			new_src_ff <= FUSE_CLK_SRC;
		end else if (fail_cnt_ff == 6'(`FAIL_TIMEOUT - 1)) begin
			cur_src_ff <= SRC_FAST_RC;
		end else if (WR_STB && ADDR == `REG_CLKCTL) begin
			new_src_ff <= WDATA[`CLK_NEW_LSB +: 3];
			if (WDATA[`CLK_SWITCH_BIT] && WDATA[`CLK_NEW_LSB +: 3] <= 3'(SRC_EXT_CLOCK))
				cur_src_ff <= WDATA[`CLK_NEW_LSB +: 3];
		end
	end

	// Software control bits.
	always_ff @(posedge CLOCK) begin
		if (SYS_RST || por_s) begin
			wdog_soft_en_ff <= 1'b0;
			tap_sel_ff <= 4'h0;
			ext_tap_ff <= 1'b0;
			supply_en_ff <= 1'b0;
			idle_stop_ff <= NUM_PERIPH'(`IDLESTOP_RESET);
		end else if (WR_STB) begin
			if (ADDR == `REG_WDOG) wdog_soft_en_ff <= WDATA[`WDOG_SOFT_EN_BIT];
			if (ADDR == `REG_SUPPLY) begin
				tap_sel_ff <= WDATA[`SUP_TAP_LSB +: 4];
				ext_tap_ff <= WDATA[`SUP_EXT_BIT];
				supply_en_ff <= WDATA[`SUP_EN_BIT];
			end
			if (ADDR == `REG_IDLESTOP) idle_stop_ff <= WDATA[NUM_PERIPH-1:0];
		end
	end

	// Supply flag: set wins over a software clear.
	always_ff @(posedge CLOCK) begin
		if (SYS_RST) supply_flag_ff <= 1'b0;
		else if (supply_low) supply_flag_ff <= 1'b1;
		else if (WR_STB && ADDR == `REG_SUPPLY && WDATA[`SUP_FLAG_BIT]) supply_flag_ff <= 1'b0;
	end

	// Sticky reset causes; a new cause wins over a software clear.
	always_ff @(posedge CLOCK) begin
		por_seen_ff <= SYS_RST ? 1'b0 : por_s;
		if (SYS_RST) cause_ff <= 8'(`CAUSE_RESET);
		else if (WR_STB && ADDR == `REG_RSTCAUSE) cause_ff <= (cause_ff & ~WDATA[7:0]) | causes;
		else cause_ff <= cause_ff | causes;
	end

	// ------------------------------------------------------------------------
	// Outputs and read port
	// ------------------------------------------------------------------------
	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			MASTER_RESET <= 1'b1;
			CPU_CLOCK_EN <= 1'b0;
			SYS_CLOCK_EN <= 1'b0;
			PERIPH_CLOCK_EN <= '0;
			CLOCK_SOURCE <= FUSE_CLK_SRC;
			CLOCK_FAIL_TRAP <= 1'b0;
			RC_OSC_ENABLE <= 1'b0;
			SUPPLY_DETECT_FLAG <= 1'b0;
			DETECTORS_ACTIVE <= 1'b0;
			WAKE_EVENT <= 1'b0;
		end else begin
			MASTER_RESET <= nxt_state inside {ST_POWERUP, ST_STARTUP, ST_RESET};
			CPU_CLOCK_EN <= nxt_state == ST_RUN;
			SYS_CLOCK_EN <= nxt_state inside {ST_RUN, ST_IDLE};
			PERIPH_CLOCK_EN <= nxt_state == ST_RUN ? {NUM_PERIPH{1'b1}} :
				nxt_state == ST_IDLE ? ~idle_stop_ff : '0;
			CLOCK_SOURCE <= cur_src_ff;
			CLOCK_FAIL_TRAP <= fail_ff;
			RC_OSC_ENABLE <= wdog_en || (clock_fail_monitor_en && nxt_state != ST_SLEEP);
			SUPPLY_DETECT_FLAG <= supply_flag_ff;
			DETECTORS_ACTIVE <= supply_en_ff | BROWNOUT_EN;
			WAKE_EVENT <= (state_ff inside {ST_SLEEP, ST_IDLE}) && nxt_state != state_ff;
		end
	end

	// Read data, valid in the cycle after the read strobe.
	always_ff @(posedge CLOCK) begin
		if (SYS_RST || !RD_STB) RDATA <= 16'h0;
		else begin
			case (ADDR)
				`REG_CLKCTL: RDATA <= {3'h0, crystal_mode, 1'b0, cur_src_ff, 3'h0, fail_ff, 1'b0, new_src_ff};
				`REG_WDOG: RDATA <= {wdog_cnt_ff[13:0], 1'b0, wdog_soft_en_ff};
				`REG_SUPPLY: RDATA <= {7'h0, supply_flag_ff, 2'h0, supply_en_ff, ext_tap_ff, tap_sel_ff};
				`REG_RSTCAUSE: RDATA <= {7'h0, por_seen_ff, cause_ff};
				`REG_PWRSAVE: RDATA <= {10'h0, state_ff};
				`REG_IDLESTOP: RDATA <= 16'(idle_stop_ff);
				default: RDATA <= 16'h0;
			endcase
		end
	end
endmodule // system_reset_power_manager

// ==== hdl/sysmgr_defs.svh ====
/*
 * Timing counts, register offsets, field positions and reset values of the system reset and power manager.
 * Assumes inclusion by bare name from hdl/; definitions only.
 */
`ifndef SYSMGR_DEFS_SVH
`define SYSMGR_DEFS_SVH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define OSC_STARTUP_COUNT 1024
`define OSC_STARTUP_WIDTH 10
`define PWRUP_DELAY_NS 64000
`define CLOCK_PERIOD_NS 10
`define PWRUP_DELAY_CYCLES (`PWRUP_DELAY_NS / `CLOCK_PERIOD_NS)
`define WDOG_WIDTH 16
`define FAIL_TIMEOUT 32

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define REG_CLKCTL 4'h0
`define REG_WDOG 4'h1
`define REG_SUPPLY 4'h2
`define REG_RSTCAUSE 4'h3
`define REG_PWRSAVE 4'h4
`define REG_IDLESTOP 4'h5

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define CLK_NEW_LSB 0
`define CLK_SWITCH_BIT 3
`define CLK_FAIL_BIT 4
`define CLK_CUR_LSB 8
`define CLK_LOCK_BIT 12
`define WDOG_SOFT_EN_BIT 0
`define WDOG_CLEAR_BIT 1
`define SUP_TAP_LSB 0
`define SUP_EXT_BIT 4
`define SUP_EN_BIT 5
`define SUP_FLAG_BIT 8
`define CAUSE_RESET 16'h0001
`define IDLESTOP_RESET 16'h0000

`endif

// ==== hdl/sysmgr_pkg.sv ====
/*
 * Types of the system reset and power manager: clock sources and power states.
 * Assumes the timing and offset macros come from sysmgr_defs.svh.
 */
package sysmgr_pkg;
	// Clock source selection codes.
	typedef enum logic [2:0] {
		SRC_FAST_RC = 3'h0,
		SRC_LOW_POWER_XTAL = 3'h1,
		SRC_LOW_RANGE_XTAL = 3'h2,
		SRC_STD_XTAL = 3'h3,
		SRC_HIGH_SPEED_XTAL = 3'h4,
		SRC_EXT_RC = 3'h5,
		SRC_EXT_CLOCK = 3'h6
	} clk_src_e;

	// Power and reset sequencing states, one-hot.
	typedef enum logic [5:0] {
		ST_POWERUP = 6'b000001,
		ST_STARTUP = 6'b000010,
		ST_RUN = 6'b000100,
		ST_IDLE = 6'b001000,
		ST_SLEEP = 6'b010000,
		ST_RESET = 6'b100000
	} pwr_state_e;
endpackage

// ==== dv/osc_partner.sv ====
/* Oscillator model on the far side of the manager: a crystal that can fail and a free-running RC.
   Assumes the bench clock; run low freezes the crystal as a dead one would. */
`timescale 1ns/1ns
module osc_partner (
	input wire logic clock,
	input wire logic run,
	output logic xtal_tick,
	output logic rc_tick
);
	logic [1:0] xtal_ff = 2'h0;
	logic [2:0] rc_ff = 3'h0;
	// Crystal period is four cycles; a failed one holds its level.
	always_ff @(posedge clock) begin
		if (run) begin
			xtal_ff <= xtal_ff + 2'h1;
		end
	end
	// The RC period is six cycles and it never stops, so the watchdog outlives the crystal.
	always_ff @(posedge clock) begin
		rc_ff <= (rc_ff == 3'h5) ? 3'h0 : rc_ff + 3'h1;
	end
	// Square waves from the two dividers.
	assign xtal_tick = xtal_ff[1];
	assign rc_tick = (rc_ff > 3'h2);
endmodule // osc_partner

// ==== dv/sysmgr_monitor.sv ====
/* Port checker of the system reset and power manager.
   Assumes it is bound into the top module and sees only its ports. */
`timescale 1ns/1ns
module sysmgr_monitor
	import sysmgr_pkg::*;
#(
	parameter int NUM_PERIPH = 16
) (
	input wire logic CLOCK,
	input wire logic SYS_RST,
	input wire logic RESET_INSTRUCTION,
	input wire logic TRAP_CONFLICT,
	input wire logic ILLEGAL_OP,
	input wire logic CLOCK_FAIL_MONITOR_EN,
	input wire logic POWER_SAVE_INSTRUCTION,
	input wire logic POWER_SAVE_SLEEP,
	input wire logic IRQ_PENDING,
	input wire logic MASTER_RESET,
	input wire logic CPU_CLOCK_EN,
	input wire logic SYS_CLOCK_EN,
	input wire logic [NUM_PERIPH-1:0] PERIPH_CLOCK_EN,
	input wire logic [2:0] CLOCK_SOURCE,
	input wire logic CLOCK_FAIL_TRAP,
	input wire logic RC_OSC_ENABLE
);
	logic [12:0] hold_ff;
	logic run;
	// Counts how long master reset has stood, saturating at 4096 cycles, about the crystal start-up span.
	always_ff @(posedge CLOCK) begin
		if (SYS_RST || !MASTER_RESET) begin
			hold_ff <= 13'h0;
		end else if (!hold_ff[12]) begin
			hold_ff <= hold_ff + 13'h1;
		end
	end
	// Running means out of reset with the CPU clocked and nothing pending.
	assign run = CPU_CLOCK_EN && !MASTER_RESET && !IRQ_PENDING;
	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (SYS_RST);
	AST_START_HOLD: assert property ($fell(MASTER_RESET) && CLOCK_SOURCE inside {3'h1, 3'h2, 3'h3, 3'h4}
		|-> hold_ff >= 13'd2046) else $error("crystal start-up released early");
	AST_PWRUP_HOLD: assert property ($fell(SYS_RST) |-> MASTER_RESET [*8])
		else $error("power-up delay too short");
	AST_CAUSE: assert property ((RESET_INSTRUCTION || TRAP_CONFLICT || ILLEGAL_OP) |-> ##[1:3] MASTER_RESET)
		else $error("reset cause ignored");
	AST_FAIL_SRC: assert property ($rose(CLOCK_FAIL_TRAP) |-> ##[0:2] (CLOCK_SOURCE == 3'h0))
		else $error("no fallback to fast RC");
	AST_NO_MON_SLEEP: assert property ($rose(CLOCK_FAIL_TRAP) |-> $past(SYS_CLOCK_EN))
		else $error("monitor fired with clock stopped");
	AST_RC_MON: assert property ((CLOCK_FAIL_MONITOR_EN && SYS_CLOCK_EN) [*4] |-> RC_OSC_ENABLE)
		else $error("RC off under monitor");
	AST_SLEEP_STOP: assert property (POWER_SAVE_INSTRUCTION && POWER_SAVE_SLEEP && run
		|-> ##[1:3] (!SYS_CLOCK_EN && PERIPH_CLOCK_EN == '0)) else $error("sleep left clocks on");
	AST_IDLE_STOP: assert property (POWER_SAVE_INSTRUCTION && !POWER_SAVE_SLEEP && run
		|-> ##[1:3] (!CPU_CLOCK_EN && SYS_CLOCK_EN)) else $error("idle entry wrong");
	AST_IDLE_WAKE: assert property (!CPU_CLOCK_EN && SYS_CLOCK_EN && !MASTER_RESET && IRQ_PENDING
		|-> ##[1:3] CPU_CLOCK_EN) else $error("idle wake slow");
endmodule // sysmgr_monitor
bind system_reset_power_manager sysmgr_monitor #(.NUM_PERIPH(NUM_PERIPH)) u_sysmgr_monitor (.*);

// ==== dv/testbench.sv ====
/* Self-checking bench of the system reset and power manager.
   Assumes the oscillator model and the bound checker are compiled first. */
`timescale 1ns/1ns
`include "sysmgr_defs.svh"
module testbench
	import sysmgr_pkg::*;
;
	logic CLOCK = 1'b0, SYS_RST = 1'b1, POWER_ON_EVENT = 1'b0, BROWNOUT_EVENT = 1'b0, MASTER_CLEAR_PIN_N = 1'b1;
	logic RESET_INSTRUCTION = 1'b0, TRAP_CONFLICT = 1'b0, ILLEGAL_OP = 1'b0, WATCHDOG_FUSE_ENABLE = 1'b0;
	logic CLOCK_FAIL_MONITOR_EN = 1'b0, BROWNOUT_EN = 1'b1, SUPPLY_DETECT_EXT_INPUT = 1'b0, IRQ_PENDING = 1'b0;
	logic POWER_SAVE_INSTRUCTION = 1'b0, POWER_SAVE_SLEEP = 1'b0, WR_STB = 1'b0, RD_STB = 1'b0, osc_run = 1'b1;
	logic [15:0] SUPPLY_TAP_BELOW = 16'h0, WDATA = 16'h0, RDATA, PERIPH_CLOCK_EN, d;
	logic [3:0] ADDR = 4'h0;
	logic [2:0] CLOCK_SOURCE;
	logic RC_OSC_TICK, PRIMARY_OSC_TICK, MASTER_RESET, CPU_CLOCK_EN, SYS_CLOCK_EN, CLOCK_FAIL_TRAP;
	logic RC_OSC_ENABLE, SUPPLY_DETECT_FLAG, DETECTORS_ACTIVE, WAKE_EVENT;
	int n_mismatch = 0, num_checks = 0, n;
	// Short power-up count keeps the run brief.
	system_reset_power_manager #(.PWRUP_CYCLES(20)) u_system_reset_power_manager (.*);
	// Crystal and RC sources.
	osc_partner u_osc_partner (.clock(CLOCK), .run(osc_run), .xtal_tick(PRIMARY_OSC_TICK),
		.rc_tick(RC_OSC_TICK));
	// The 100 MHz clock.
	always #5 CLOCK = ~CLOCK;
	// Compares one value and logs a mismatch.
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// One-cycle register write.
	task automatic wr(input logic [3:0] a, input logic [15:0] v);
		@(posedge CLOCK);
		ADDR <= a;
		WDATA <= v;
		WR_STB <= 1'b1;
		@(posedge CLOCK);
		WR_STB <= 1'b0;
	endtask
	// One-cycle register read; data is taken in the following cycle.
	task automatic rd(input logic [3:0] a);
		@(posedge CLOCK);
		ADDR <= a;
		RD_STB <= 1'b1;
		@(posedge CLOCK);
		RD_STB <= 1'b0;
		#1 d = RDATA;
	endtask
	// Counts cycles until the chip runs again, bounded.
	task automatic wait_run();
		n = 0;
		while (!(SYS_CLOCK_EN === 1'b1 && MASTER_RESET === 1'b0) && n < 6000) begin
			@(negedge CLOCK);
			n++;
		end
	endtask
	// Issues the power-save instruction and lets it land.
	task automatic pse(input logic s);
		@(posedge CLOCK);
		POWER_SAVE_SLEEP <= s;
		POWER_SAVE_INSTRUCTION <= 1'b1;
		@(posedge CLOCK);
		POWER_SAVE_INSTRUCTION <= 1'b0;
		repeat (4) @(negedge CLOCK);
	endtask
	// Power-up keeps reset through the crystal start-up, on the fuse source.
	task automatic t_powerup();
		repeat (30) @(negedge CLOCK);
		chk("reset_held", MASTER_RESET, 1'b1);
		chk("fuse_src", CLOCK_SOURCE, SRC_STD_XTAL);
		wait_run();
		chk("startup_len", n >= 4000, 1'b1);
		rd(`REG_RSTCAUSE);
		chk("por_cause", d, `CAUSE_RESET);
	endtask
	// Brown-out, instruction, pin, trap and opcode causes each reset, rerun start-up and are logged alone.
	task automatic t_causes();
		int b[5] = '{1, 2, 3, 5, 6};
		wr(`REG_RSTCAUSE, 16'h007f);
		for (int k = 0; k < 5; k++) begin
			@(posedge CLOCK);
			BROWNOUT_EVENT <= (k == 0);
			RESET_INSTRUCTION <= (k == 1);
			MASTER_CLEAR_PIN_N <= (k != 2);
			TRAP_CONFLICT <= (k == 3);
			ILLEGAL_OP <= (k == 4);
			repeat (4) @(posedge CLOCK);
			{BROWNOUT_EVENT, RESET_INSTRUCTION, TRAP_CONFLICT, ILLEGAL_OP} <= 4'h0;
			MASTER_CLEAR_PIN_N <= 1'b1;
			@(negedge CLOCK);
			chk("cause_reset", MASTER_RESET, 1'b1);
			wait_run();
			chk("restart_len", n >= 4000, 1'b1);
			rd(`REG_RSTCAUSE);
			chk("cause_bit", d, 16'h1 << b[k]);
			wr(`REG_RSTCAUSE, 16'h007f);
		end
	endtask
	// Idle halts only the CPU and stopped peripherals and restarts the watchdog.
	task automatic t_idle();
		wr(`REG_WDOG, 16'h0001);
		wr(`REG_IDLESTOP, 16'h00f0);
		repeat (200) @(posedge CLOCK);
		rd(`REG_WDOG);
		chk("wdog_runs", d[15:2] > 14'd20, 1'b1);
		wr(`REG_WDOG, 16'h0003);
		rd(`REG_WDOG);
		chk("wdog_soft_clr", d[15:2] < 14'd3, 1'b1);
		repeat (200) @(posedge CLOCK);
		pse(1'b0);
		chk("cpu_off", CPU_CLOCK_EN, 1'b0);
		chk("sys_on", SYS_CLOCK_EN, 1'b1);
		chk("periph", PERIPH_CLOCK_EN, 16'hff0f);
		rd(`REG_WDOG);
		chk("wdog_clr", d[15:2] < 14'd4, 1'b1);
		@(posedge CLOCK);
		IRQ_PENDING <= 1'b1;
		repeat (3) @(negedge CLOCK);
		chk("cpu_back", CPU_CLOCK_EN, 1'b1);
		@(posedge CLOCK);
		IRQ_PENDING <= 1'b0;
	endtask
	// Sleep stops the clocks, keeps detectors and RC alive, and wakes through start-up.
	task automatic t_sleep();
		pse(1'b1);
		chk("sys_off", SYS_CLOCK_EN, 1'b0);
		chk("periph_off", PERIPH_CLOCK_EN, 16'h0000);
		chk("detectors", DETECTORS_ACTIVE, 1'b1);
		chk("rc_on", RC_OSC_ENABLE, 1'b1);
		@(posedge CLOCK);
		IRQ_PENDING <= 1'b1;
		wait_run();
		chk("wake_len", n >= 4000, 1'b1);
		@(posedge CLOCK);
		IRQ_PENDING <= 1'b0;
	endtask
	// A dead crystal traps and falls back; software then switches sources.
	task automatic t_fail();
		@(posedge CLOCK);
		CLOCK_FAIL_MONITOR_EN <= 1'b1;
		repeat (10) @(posedge CLOCK);
		osc_run <= 1'b0;
		repeat (60) @(negedge CLOCK);
		chk("trap", CLOCK_FAIL_TRAP, 1'b1);
		chk("fallback", CLOCK_SOURCE, SRC_FAST_RC);
		chk("rc_mon", RC_OSC_ENABLE, 1'b1);
		@(posedge CLOCK);
		osc_run <= 1'b1;
		wr(`REG_CLKCTL, 16'h0010);
		wr(`REG_CLKCTL, 16'h000b);
		repeat (3) @(negedge CLOCK);
		chk("trap_clr", CLOCK_FAIL_TRAP, 1'b0);
		chk("switched", CLOCK_SOURCE, SRC_STD_XTAL);
		wr(`REG_CLKCTL, 16'h000f);
		rd(4'hf);
		chk("bad_code", CLOCK_SOURCE, SRC_STD_XTAL);
		chk("unmapped", d, 16'h0000);
	endtask
	// Only the selected tap sets the supply flag; a one written clears it.
	task automatic t_supply();
		wr(`REG_SUPPLY, 16'h0025);
		SUPPLY_TAP_BELOW <= 16'hffdf;
		repeat (6) @(negedge CLOCK);
		chk("other_taps", SUPPLY_DETECT_FLAG, 1'b0);
		@(posedge CLOCK);
		SUPPLY_TAP_BELOW <= 16'h0020;
		repeat (6) @(negedge CLOCK);
		chk("tap_flag", SUPPLY_DETECT_FLAG, 1'b1);
		@(posedge CLOCK);
		SUPPLY_TAP_BELOW <= 16'h0000;
		repeat (4) @(posedge CLOCK);
		wr(`REG_SUPPLY, 16'h0125);
		repeat (2) @(negedge CLOCK);
		chk("flag_clr", SUPPLY_DETECT_FLAG, 1'b0);
	endtask
	// Prints the counts and the verdict, then ends the run.
	task automatic stop_test();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// Main sequence after three cycles of reset.
	initial begin
		repeat (3) @(posedge CLOCK);
		SYS_RST <= 1'b0;
		t_powerup();
		t_causes();
		t_idle();
		t_sleep();
		t_fail();
		t_supply();
		stop_test();
	end
	// Cuts a hang short; the tests need just under half this span.
	initial begin
		#600000;
		n_mismatch++;
		stop_test();
	end
endmodule // testbench
